// ==== sim/drive_power_checker.sv ====
`timescale 1ns/100ps
module drive_power_checker
(
	input wire logic                               clock,
	input wire logic                               resetn,
	input wire logic                               init_done,
	input wire logic                               fault_cause_done,
	input wire logic                               obj_write,
	input wire logic                               obj_read,
	input wire logic [15:0]                        obj_index,
	input wire logic [15:0]                        obj_wdata,
	input wire logic                               obj_ack,
	input wire logic                               obj_refused,
	input wire logic                               uv_select,
	input wire drive_power_pkg::power_drive_state_t power_drive_state,
	input wire logic                               servo_on,
	input wire logic                               errors_clear
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	property p_ack;
		(obj_write || obj_read) |=> obj_ack ##1 !obj_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("strobe not acknowledged once");
	property p_no_ack;
		!(obj_write || obj_read) |=> !obj_ack;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("acknowledge without strobe");
	property p_refuse;
		obj_write |=> (obj_refused == ($past(power_drive_state) == drive_power_pkg::pds_init));
	endproperty
	a_refuse: assert property (p_refuse) else $error("write refusal wrong");
	property p_init_hold;
		power_drive_state == drive_power_pkg::pds_init && !init_done |=>
			power_drive_state == drive_power_pkg::pds_init;
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("left init early");
	property p_init_exit;
		power_drive_state == drive_power_pkg::pds_init && init_done |=>
			power_drive_state == drive_power_pkg::pds_switch_on_disabled;
	endproperty
	a_init_exit: assert property (p_init_exit) else $error("init exit wrong");
	property p_servo;
		servo_on == (power_drive_state == drive_power_pkg::pds_operation_enabled);
	endproperty
	a_servo: assert property (p_servo) else $error("servo level wrong");
	property p_clear;
		errors_clear |-> power_drive_state == drive_power_pkg::pds_switch_on_disabled && !$past(errors_clear);
	endproperty
	a_clear: assert property (p_clear) else $error("error clear wrong");
	property p_react_hold;
		power_drive_state == drive_power_pkg::pds_fault_reaction && !fault_cause_done |=>
			$stable(power_drive_state);
	endproperty
	a_react_hold: assert property (p_react_hold) else $error("fault reaction left early");
	property p_uv;
		obj_write && obj_index == drive_power_pkg::uv_select_index &&
			power_drive_state != drive_power_pkg::pds_init |=> uv_select == $past(obj_wdata[0]);
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage select not stored");
endmodule : drive_power_checker

bind drive_power_state_machine drive_power_checker chk (.clock, .resetn, .init_done,
	.fault_cause_done, .obj_write, .obj_read, .obj_index, .obj_wdata, .obj_ack, .obj_refused,
	.uv_select, .power_drive_state, .servo_on, .errors_clear);

// ==== sim/fieldbus_master.sv ====
`timescale 1ns/100ps
module fieldbus_master
(
	input wire logic        clock,
	input wire logic        obj_ack,
	input wire logic        obj_refused,
	input wire logic [15:0] obj_rdata,
	output logic            obj_write,
	output logic            obj_read,
	output logic     [15:0] obj_index,
	output logic     [15:0] obj_wdata
);
	initial
	begin
		obj_write = 1'b0;
		obj_read = 1'b0;
		obj_index = 16'h0000;
		obj_wdata = 16'h0000;
	end

	// Released lines show the inverse so stale values never look valid
	task access(input logic rd, input logic [15:0] idx, input logic [15:0] data,
		output logic [15:0] q, output logic refd, output logic ok);
		int n;
		@(posedge clock);
		obj_read <= rd;
		obj_write <= !rd;
		obj_index <= idx;
		obj_wdata <= data;
		@(posedge clock);
		obj_read <= 1'b0;
		obj_write <= 1'b0;
		obj_index <= ~idx;
		obj_wdata <= ~data;
		ok = 1'b0;
		for (n = 0; n < 4 && !ok; n++)
		begin
			@(posedge clock);
			ok = (obj_ack === 1'b1);
		end
		q = obj_rdata;
		refd = obj_refused;
	endtask : access
endmodule : fieldbus_master

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	logic        clock, resetn, init_done, main_power_pin, fault_detect_pin, fault_cause_done;
	logic        warning_event, obj_write, obj_read, obj_ack, obj_refused, uv_select;
	logic        servo_on, errors_clear, refd, ok;
	logic [15:0] obj_index, obj_wdata, obj_rdata, q;
	int          err_count, cmp_count;
	drive_power_pkg::power_drive_state_t power_drive_state;

	always #2.5 clock = ~clock;

	drive_power_state_machine uut (.clock, .resetn, .init_done, .main_power_pin,
		.fault_detect_pin, .fault_cause_done, .warning_event, .obj_write, .obj_read,
		.obj_index, .obj_wdata, .obj_rdata, .obj_ack, .obj_refused, .uv_select,
		.power_drive_state, .servo_on, .errors_clear);
	fieldbus_master master (.clock, .obj_ack, .obj_refused, .obj_rdata, .obj_write,
		.obj_read, .obj_index, .obj_wdata);

	task tally_and_finish;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task acc(input logic rd, input logic [15:0] idx, input logic [15:0] data);
		master.access(rd, idx, data, q, refd, ok);
		if (!ok)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask : acc

	task cmd(input logic [15:0] data);
		acc(1'b0, drive_power_pkg::cmd_word_index, data);
	endtask : cmd

	// Settling time covers the two-stage pin synchronisers
	task st(input logic [5:0] exp);
		repeat (4) @(posedge clock);
		acc(1'b1, drive_power_pkg::state_word_index, 16'h0000);
		check({10'h000, q[6], q[5], q[3:0]}, {10'h000, exp});
	endtask : st

	initial
	begin
		clock = 1'b0;
		resetn = 1'b0;
		{init_done, main_power_pin, fault_detect_pin, fault_cause_done, warning_event} = 5'h00;
		err_count = 0;
		cmp_count = 0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		cmd(16'h0006);
		check({15'h0000, refd}, 16'h0001);
		st(drive_power_pkg::pat_init);
		init_done <= 1'b1;
		main_power_pin <= 1'b1;
		st(drive_power_pkg::pat_sw_disab);
		cmd(16'h0006);
		check({15'h0000, refd}, 16'h0000);
		st(drive_power_pkg::pat_ready);
		cmd(16'h0002);
		st(drive_power_pkg::pat_ready);
		cmd(16'h000f);
		st(drive_power_pkg::pat_op_en);
		check({15'h0000, q[4]}, 16'h0001);
		cmd(16'h0007);
		st(drive_power_pkg::pat_sw_on);
		cmd(16'h0000);
		st(drive_power_pkg::pat_sw_disab);
		cmd(16'h0007);
		st(drive_power_pkg::pat_sw_disab);
		cmd(16'h0006);
		cmd(16'h000f);
		warning_event <= 1'b1;
		@(posedge clock);
		warning_event <= 1'b0;
		st(drive_power_pkg::pat_op_en);
		check({15'h0000, q[7]}, 16'h0001);
		cmd(16'h008f);
		st(drive_power_pkg::pat_op_en);
		check({15'h0000, q[7]}, 16'h0000);
		cmd(16'h000f);
		fault_detect_pin <= 1'b1;
		st(drive_power_pkg::pat_fault_rx);
		fault_cause_done <= 1'b1;
		repeat (2) @(posedge clock);
		fault_detect_pin <= 1'b0;
		fault_cause_done <= 1'b0;
		st(drive_power_pkg::pat_fault);
		check({13'h0000, power_drive_state}, {13'h0000, drive_power_pkg::pds_fault});
		cmd(16'h0080);
		check({15'h0000, errors_clear}, 16'h0001);
		st(drive_power_pkg::pat_sw_disab);
		cmd(16'h0000);
		acc(1'b0, drive_power_pkg::uv_select_index, 16'h0001);
		check({15'h0000, uv_select}, 16'h0001);
		cmd(16'h0006);
		cmd(16'h000f);
		st(drive_power_pkg::pat_op_en);
		check({15'h0000, servo_on}, 16'h0001);
		main_power_pin <= 1'b0;
		st(drive_power_pkg::pat_fault_rx);
		check({15'h0000, servo_on}, 16'h0000);
		fault_cause_done <= 1'b1;
		@(posedge clock);
		fault_cause_done <= 1'b0;
		main_power_pin <= 1'b1;
		st(drive_power_pkg::pat_fault);
		cmd(16'h0080);
		check({15'h0000, errors_clear}, 16'h0001);
		cmd(16'h0000);
		acc(1'b0, drive_power_pkg::uv_select_index, 16'h0000);
		check({15'h0000, uv_select}, 16'h0000);
		cmd(16'h0006);
		cmd(16'h000f);
		st(drive_power_pkg::pat_op_en);
		main_power_pin <= 1'b0;
		st(drive_power_pkg::pat_ready);
		acc(1'b1, 16'h1234, 16'h0000);
		check(q, 16'h0000);
		tally_and_finish();
	end
endmodule : tb_top

// ==== verilog/drive_power_pkg.sv ====
package drive_power_pkg;

	localparam logic [15:0] cmd_word_index     = 16'h6040;
	localparam logic [15:0] state_word_index   = 16'h6041;
	localparam logic [15:0] uv_select_index    = 16'h3508;
	localparam logic [15:0] cmd_word_reset     = 16'h0000;
	localparam logic        uv_select_reset    = 1'h0;

	// Command word bit positions
	localparam int cmd_switch_on_bit   = 0;
	localparam int cmd_enable_volt_bit = 1;
	localparam int cmd_quick_stop_bit  = 2;
	localparam int cmd_enable_op_bit   = 3;
	localparam int cmd_fault_reset_bit = 7;

	// State word bit positions
	localparam int st_ready_bit        = 0;
	localparam int st_switched_on_bit  = 1;
	localparam int st_op_enabled_bit   = 2;
	localparam int st_fault_bit        = 3;
	localparam int st_voltage_bit      = 4;
	localparam int st_quick_stop_bit   = 5;
	localparam int st_sw_disabled_bit  = 6;
	localparam int st_warning_bit      = 7;

	// State patterns on bits 6,5,3,2,1,0
	localparam logic [5:0] pat_init      = 6'h00;
	localparam logic [5:0] pat_sw_disab  = 6'h30;
	localparam logic [5:0] pat_ready     = 6'h11;
	localparam logic [5:0] pat_sw_on     = 6'h13;
	localparam logic [5:0] pat_op_en     = 6'h17;
	localparam logic [5:0] pat_fault_rx  = 6'h1f;
	localparam logic [5:0] pat_fault     = 6'h18;

	typedef enum logic [2:0]
	{
		pds_init,
		pds_switch_on_disabled,
		pds_ready_to_switch_on,
		pds_switched_on,
		pds_operation_enabled,
		pds_fault_reaction,
		pds_fault
	} power_drive_state_t;

endpackage : drive_power_pkg

// ==== verilog/drive_power_state_machine.sv ====
`timescale 1ns/100ps
// Behaviour
// - Hold initializing during internal init, then enter switch-on-disabled unprompted.
// - Accept configuration parameter writes in every state except initializing.
// - Ready-to-switch-on invites main power; switched-on means main power present.
// - Shutdown is bits 2,1 set, bit 0 clear; disable-voltage is bit 1 clear.
// - Bits 2..0 set: bit 3 clear gives switched-on, set gives operation-enabled.
// - Enable-operation from ready passes through switched-on, then operation-enabled.
// - Quick stop (bit 2 clear, bit 1 set) is ignored, no state change.
// - In fault, rising control bit 7 clears errors and returns to switch-on-disabled.
// - Rising control bit 7 clears the warning flag in status bit 7.
// - Bit 7 rising outside fault changes no state; bits 0 to 3 still steer.
// - Status bits 6,5,3,2,1,0 report each state pattern, bit 4 shows main power.
// - While fault cause is determined, report fault-reaction-active pattern 011111.
// - Established fault reports 011000 with bit 3 marking the fault.
// - Commands come from the command word object, state goes to state word.
// - Main power loss in operation: select 1 faults, select 0 drops power state.
module drive_power_state_machine
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        init_done,
	input  wire logic        main_power_pin,
	input  wire logic        fault_detect_pin,
	input  wire logic        fault_cause_done,
	input  wire logic        warning_event,
	input  wire logic        obj_write,
	input  wire logic        obj_read,
	input  wire logic [15:0] obj_index,
	input  wire logic [15:0] obj_wdata,
	output logic      [15:0] obj_rdata,
	output logic             obj_ack,
	output logic             obj_refused,
	output logic             uv_select,
	output drive_power_pkg::power_drive_state_t power_drive_state,
	output logic             servo_on,
	output logic             errors_clear
);

	logic main_power;
	logic fault_detect;

	pin_sync power_sync
	(
		.clock     (clock),
		.resetn    (resetn),
		.pin_in    (main_power_pin),
		.level_out (main_power)
	);

	pin_sync fault_sync
	(
		.clock     (clock),
		.resetn    (resetn),
		.pin_in    (fault_detect_pin),
		.level_out (fault_detect)
	);

	drive_power_pkg::power_drive_state_t state_q;
	drive_power_pkg::power_drive_state_t state_d;
	logic [15:0] cmd_q;
	logic [15:0] cmd_d;
	logic        uv_q;
	logic        uv_d;
	logic        warn_q;
	logic        warn_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        ack_q;
	logic        ack_d;
	logic        refused_q;
	logic        refused_d;
	logic        clear_q;
	logic        clear_d;
	logic        cmd_wr;
	logic        reset_edge;
	logic        cmd_shutdown;
	logic        cmd_disable_volt;
	logic        cmd_switch_on;
	logic        cmd_enable_op;
	logic [5:0]  pattern;
	logic [15:0] status;

	// A fault reset is an edge between the old and newly written word
	always_comb
	begin
		cmd_wr     = obj_write && (obj_index == drive_power_pkg::cmd_word_index)
			&& (state_q != drive_power_pkg::pds_init);
		reset_edge = cmd_wr && obj_wdata[drive_power_pkg::cmd_fault_reset_bit]
			&& !cmd_q[drive_power_pkg::cmd_fault_reset_bit];
	end

	// Decoding runs on the held word, so a single write can walk two steps
	always_comb
	begin
		cmd_shutdown     = cmd_q[drive_power_pkg::cmd_quick_stop_bit]
			&& cmd_q[drive_power_pkg::cmd_enable_volt_bit]
			&& !cmd_q[drive_power_pkg::cmd_switch_on_bit];
		cmd_disable_volt = !cmd_q[drive_power_pkg::cmd_enable_volt_bit];
		cmd_switch_on    = cmd_q[drive_power_pkg::cmd_quick_stop_bit]
			&& cmd_q[drive_power_pkg::cmd_enable_volt_bit]
			&& cmd_q[drive_power_pkg::cmd_switch_on_bit];
		cmd_enable_op    = cmd_switch_on && cmd_q[drive_power_pkg::cmd_enable_op_bit];
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			drive_power_pkg::pds_init:
			begin
				if (init_done)
					state_d = drive_power_pkg::pds_switch_on_disabled;
			end
			drive_power_pkg::pds_switch_on_disabled:
			begin
				if (cmd_shutdown)
					state_d = drive_power_pkg::pds_ready_to_switch_on;
			end
			drive_power_pkg::pds_ready_to_switch_on:
			begin
				if (cmd_disable_volt)
					state_d = drive_power_pkg::pds_switch_on_disabled;
				else if (cmd_switch_on && main_power)
					state_d = drive_power_pkg::pds_switched_on;
			end
			drive_power_pkg::pds_switched_on:
			begin
				if (cmd_disable_volt)
					state_d = drive_power_pkg::pds_switch_on_disabled;
				else if (cmd_shutdown || !main_power)
					state_d = drive_power_pkg::pds_ready_to_switch_on;
				else if (cmd_enable_op)
					state_d = drive_power_pkg::pds_operation_enabled;
			end
			drive_power_pkg::pds_operation_enabled:
			begin
				if (!main_power && uv_q)
					state_d = drive_power_pkg::pds_fault_reaction;
				else if (!main_power)
					state_d = drive_power_pkg::pds_ready_to_switch_on;
				else if (cmd_disable_volt)
					state_d = drive_power_pkg::pds_switch_on_disabled;
				else if (cmd_shutdown)
					state_d = drive_power_pkg::pds_ready_to_switch_on;
				else if (cmd_switch_on && !cmd_enable_op)
					state_d = drive_power_pkg::pds_switched_on;
			end
			drive_power_pkg::pds_fault_reaction:
			begin
				if (fault_cause_done)
					state_d = drive_power_pkg::pds_fault;
			end
			drive_power_pkg::pds_fault:
			begin
				if (reset_edge)
					state_d = drive_power_pkg::pds_switch_on_disabled;
			end
			default:
				state_d = drive_power_pkg::pds_init;
		endcase
		// Detected faults outrank commands; a lingering error must not stop the reaction ending
		if (fault_detect && (state_q != drive_power_pkg::pds_init)
			&& (state_q != drive_power_pkg::pds_fault_reaction)
			&& (state_q != drive_power_pkg::pds_fault))
			state_d = drive_power_pkg::pds_fault_reaction;
	end

	always_comb
	begin
		case (state_q)
			drive_power_pkg::pds_switch_on_disabled: pattern = drive_power_pkg::pat_sw_disab;
			drive_power_pkg::pds_ready_to_switch_on: pattern = drive_power_pkg::pat_ready;
			drive_power_pkg::pds_switched_on:        pattern = drive_power_pkg::pat_sw_on;
			drive_power_pkg::pds_operation_enabled:  pattern = drive_power_pkg::pat_op_en;
			drive_power_pkg::pds_fault_reaction:     pattern = drive_power_pkg::pat_fault_rx;
			drive_power_pkg::pds_fault:              pattern = drive_power_pkg::pat_fault;
			default:                                 pattern = drive_power_pkg::pat_init;
		endcase
		status = 16'h0000;
		status[drive_power_pkg::st_sw_disabled_bit] = pattern[5];
		status[drive_power_pkg::st_quick_stop_bit]  = pattern[4];
		status[drive_power_pkg::st_fault_bit]       = pattern[3];
		status[drive_power_pkg::st_op_enabled_bit]  = pattern[2];
		status[drive_power_pkg::st_switched_on_bit] = pattern[1];
		status[drive_power_pkg::st_ready_bit]       = pattern[0];
		status[drive_power_pkg::st_voltage_bit]     = main_power;
		status[drive_power_pkg::st_warning_bit]     = warn_q;
	end

	always_comb
	begin
		cmd_d     = cmd_wr ? obj_wdata : cmd_q;
		uv_d      = uv_q;
		refused_d = 1'b0;
		ack_d     = obj_write || obj_read;
		rdata_d   = rdata_q;
		clear_d   = reset_edge && (state_q == drive_power_pkg::pds_fault);
		// A warning arriving with the clearing edge survives: set wins
		warn_d    = warning_event || (warn_q && !reset_edge);
		if (obj_write && (state_q == drive_power_pkg::pds_init))
			refused_d = 1'b1;
		else if (obj_write && (obj_index == drive_power_pkg::uv_select_index))
			uv_d = obj_wdata[0];
		if (obj_read)
		begin
			case (obj_index)
				drive_power_pkg::cmd_word_index:   rdata_d = cmd_q;
				drive_power_pkg::state_word_index: rdata_d = status;
				drive_power_pkg::uv_select_index:  rdata_d = {15'h0000, uv_q};
				default:                           rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q   <= drive_power_pkg::pds_init;
			cmd_q     <= drive_power_pkg::cmd_word_reset;
			uv_q      <= drive_power_pkg::uv_select_reset;
			warn_q    <= 1'b0;
			rdata_q   <= 16'h0000;
			ack_q     <= 1'b0;
			refused_q <= 1'b0;
			clear_q   <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			cmd_q     <= cmd_d;
			uv_q      <= uv_d;
			warn_q    <= warn_d;
			rdata_q   <= rdata_d;
			ack_q     <= ack_d;
			refused_q <= refused_d;
			clear_q   <= clear_d;
		end
	end

	always_comb
	begin
		obj_rdata         = rdata_q;
		obj_ack           = ack_q;
		obj_refused       = refused_q;
		uv_select         = uv_q;
		power_drive_state = state_q;
		servo_on          = (state_q == drive_power_pkg::pds_operation_enabled);
		errors_clear      = clear_q;
	end

endmodule : drive_power_state_machine

// ==== verilog/pin_sync.sv ====
`timescale 1ns/100ps
module pin_sync
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic pin_in,
	output logic      level_out
);

	logic meta_q;
	logic meta_d;
	logic level_d;

	always_comb
	begin
		meta_d  = pin_in;
		level_d = meta_q;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_q    <= 1'b0;
			level_out <= 1'b0;
		end
		else
		begin
			meta_q    <= meta_d;
			level_out <= level_d;
		end
	end

endmodule : pin_sync
